// ---- src/lpc_pkg.sv ----
package lpc_pkg;
   localparam int PSTATE_W = 5;
   localparam logic [PSTATE_W-1:0] PSTATE_RESET = 5'h00;
   // Sync bit positions
   localparam int SYNC_CLK_QREQN = 0;
   localparam int SYNC_PWR_QREQN = 1;
   localparam int SYNC_PACCEPT = 2;
   localparam int SYNC_W = 3;
   // Requests idle high, accept idle low
   localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h3;
   localparam logic [1:0] AGE_FULL = 2'h3;
   localparam logic QACCEPTN_RESET = 1'h1;
   localparam logic QDENY_RESET = 1'h0;
   localparam logic QACTIVE_RESET = 1'h0;

   typedef enum logic [1:0] {
      QS_RUN = 2'b00,
      QS_STOPPED = 2'b01,
      QS_DENIED = 2'b10
   } lpc_qstate_t;

   typedef enum logic [1:0] {
      PC_IDLE = 2'b00,
      PC_REQ = 2'b01,
      PC_RELEASE = 2'b10
   } lpc_pstate_t;
endpackage

// ---- src/lpc_qch.sv ----
`timescale 1ns/1ps
module lpc_qch (
   input wire logic clk,
   input wire logic rstn,
   lpc_qch_if.dev q
);
   lpc_pkg::lpc_qstate_t state;
   lpc_pkg::lpc_qstate_t next_state;
   logic next_qacceptn;
   logic next_qdeny;
   logic next_qactive;

   // Busy at the moment of the request decides between accept and deny
   always_comb begin
      next_state = state;
      case (state)
         lpc_pkg::QS_RUN: begin
            if (!q.qreqn) begin
               next_state = q.busy ? lpc_pkg::QS_DENIED : lpc_pkg::QS_STOPPED;
            end
         end
         lpc_pkg::QS_STOPPED: begin
            if (q.qreqn) begin
               next_state = lpc_pkg::QS_RUN;
            end
         end
         lpc_pkg::QS_DENIED: begin
            if (q.qreqn) begin
               next_state = lpc_pkg::QS_RUN;
            end
         end
         default: begin
            next_state = lpc_pkg::QS_RUN;
         end
      endcase
   end

   assign next_qacceptn = (next_state != lpc_pkg::QS_STOPPED);
   assign next_qdeny = (next_state == lpc_pkg::QS_DENIED);
   assign next_qactive = q.busy | q.wake;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= lpc_pkg::QS_RUN;
         q.qacceptn <= lpc_pkg::QACCEPTN_RESET;
         q.qdeny <= lpc_pkg::QDENY_RESET;
         q.qactive <= lpc_pkg::QACTIVE_RESET;
      end else begin
         state <= next_state;
         q.qacceptn <= next_qacceptn;
         q.qdeny <= next_qdeny;
         q.qactive <= next_qactive;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_stopped_exit;
      !q.qacceptn ##0 q.qreqn;
   endsequence

   sequence s_denied_exit;
      q.qdeny ##0 q.qreqn;
   endsequence

   a_accept_when_idle:
      assert property (state == lpc_pkg::QS_RUN && !q.qreqn && !q.busy
                       |=> !q.qacceptn && !q.qdeny)
      else $error("Idle request was not accepted");
   a_deny_when_busy:
      assert property (state == lpc_pkg::QS_RUN && !q.qreqn && q.busy
                       |=> q.qdeny && q.qacceptn)
      else $error("Busy request was not denied");
   a_active_tracks:
      assert property (q.busy || q.wake |=> q.qactive)
      else $error("Active missing while busy or waking");
   a_accept_hold:
      assert property (!q.qacceptn && !q.qreqn |=> !q.qacceptn [*1] ##0 !q.qdeny)
      else $error("Accept dropped while request held");
   a_accept_release:
      assert property (s_stopped_exit |=> q.qacceptn && !q.qdeny)
      else $error("Accept not released after request withdrawn");
   a_deny_release:
      assert property (s_denied_exit |=> !q.qdeny && q.qacceptn)
      else $error("Deny not released after request withdrawn");
   a_no_both:
      assert property (!(q.qdeny && !q.qacceptn))
      else $error("Accept and deny together");
endmodule

// ---- src/lpc_qch_if.sv ----
`timescale 1ns/1ps
interface lpc_qch_if;
   logic qreqn;
   logic busy;
   logic wake;
   logic qacceptn;
   logic qdeny;
   logic qactive;

   modport dev (
      input qreqn,
      input busy,
      input wake,
      output qacceptn,
      output qdeny,
      output qactive
   );

   modport top (
      output qreqn,
      output busy,
      output wake,
      input qacceptn,
      input qdeny,
      input qactive
   );
endinterface

// ---- src/lpc_top.sv ----
`timescale 1ns/1ps
// Operation
// - Both quiescence request inputs pass two flip-flops before any logic reads them.
// - Each quiescence channel drives an active-low accept when it grants the request.
// - Each quiescence channel drives deny when it refuses the request instead.
// - Each quiescence channel raises active while busy or wanting to leave quiescence.
// - A power state change is asked for by raising the active-high preq output.
// - The requested five-bit power state is shown on pstate with each request.
// - The paccept input passes a two-flop synchronizer before it is acted on.
module lpc_top (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CLK_QREQN,
   output logic CLK_QACCEPTN,
   output logic CLK_QDENY,
   output logic CLK_QACTIVE,
   input wire logic PWR_QREQN,
   output logic PWR_QACCEPTN,
   output logic PWR_QDENY,
   output logic PWR_QACTIVE,
   output logic PREQ,
   output logic [lpc_pkg::PSTATE_W-1:0] PSTATE,
   input wire logic PACCEPT,
   input wire logic CTRL_BUSY,
   input wire logic CTRL_WAKE,
   input wire logic PSTATE_REQ,
   input wire logic [lpc_pkg::PSTATE_W-1:0] PSTATE_TARGET,
   output logic PSTATE_BUSY,
   output logic PSTATE_DONE
);
   logic [lpc_pkg::SYNC_W-1:0] sync_meta;
   logic [lpc_pkg::SYNC_W-1:0] sync_out;
   logic [lpc_pkg::SYNC_W-1:0] async_in;
   logic [1:0] rst_age;
   logic paccept_s;
   lpc_pkg::lpc_pstate_t pstate_fsm;
   lpc_pkg::lpc_pstate_t next_pstate_fsm;
   logic start_req;
   logic next_preq;
   logic next_pstate_busy;
   logic next_pstate_done;

   lpc_qch_if clk_q ();
   lpc_qch_if pwr_q ();

   assign async_in = {PACCEPT, PWR_QREQN, CLK_QREQN};

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         sync_meta <= lpc_pkg::SYNC_RESET;
         sync_out <= lpc_pkg::SYNC_RESET;
      end else begin
         sync_meta <= async_in;
         sync_out <= sync_meta;
      end
   end

   // Only used to keep the sync check quiet until the pipe has filled
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         rst_age <= 2'h0;
      end else if (rst_age != lpc_pkg::AGE_FULL) begin
         rst_age <= rst_age + 2'h1;
      end
   end

   assign paccept_s = sync_out[lpc_pkg::SYNC_PACCEPT];

   // Request levels come from the controllers and may toggle at any time
   assign clk_q.qreqn = sync_out[lpc_pkg::SYNC_CLK_QREQN];
   assign pwr_q.qreqn = sync_out[lpc_pkg::SYNC_PWR_QREQN];
   assign clk_q.busy = CTRL_BUSY;
   assign clk_q.wake = CTRL_WAKE;
   // Power may not be removed mid power-state change
   assign pwr_q.busy = CTRL_BUSY | (pstate_fsm != lpc_pkg::PC_IDLE);
   assign pwr_q.wake = CTRL_WAKE;

   lpc_qch u_clk_qch (
      .clk(CLK_SYS),
      .rstn(RESETN),
      .q(clk_q.dev)
   );

   lpc_qch u_pwr_qch (
      .clk(CLK_SYS),
      .rstn(RESETN),
      .q(pwr_q.dev)
   );

   assign CLK_QACCEPTN = clk_q.qacceptn;
   assign CLK_QDENY = clk_q.qdeny;
   assign CLK_QACTIVE = clk_q.qactive;
   assign PWR_QACCEPTN = pwr_q.qacceptn;
   assign PWR_QDENY = pwr_q.qdeny;
   assign PWR_QACTIVE = pwr_q.qactive;

   // New request only once the previous handshake has fully closed
   assign start_req = (pstate_fsm == lpc_pkg::PC_IDLE) && PSTATE_REQ && !paccept_s;

   // No deny path: a raised request always ends in accept
   always_comb begin
      next_pstate_fsm = pstate_fsm;
      case (pstate_fsm)
         lpc_pkg::PC_IDLE: begin
            if (start_req) begin
               next_pstate_fsm = lpc_pkg::PC_REQ;
            end
         end
         lpc_pkg::PC_REQ: begin
            if (paccept_s) begin
               next_pstate_fsm = lpc_pkg::PC_RELEASE;
            end
         end
         lpc_pkg::PC_RELEASE: begin
            if (!paccept_s) begin
               next_pstate_fsm = lpc_pkg::PC_IDLE;
            end
         end
         default: begin
            next_pstate_fsm = lpc_pkg::PC_IDLE;
         end
      endcase
   end

   assign next_preq = (next_pstate_fsm == lpc_pkg::PC_REQ);
   assign next_pstate_busy = (next_pstate_fsm != lpc_pkg::PC_IDLE);
   assign next_pstate_done = (pstate_fsm == lpc_pkg::PC_RELEASE) && !paccept_s;

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         pstate_fsm <= lpc_pkg::PC_IDLE;
         PREQ <= 1'h0;
         PSTATE_BUSY <= 1'h0;
         PSTATE_DONE <= 1'h0;
      end else begin
         pstate_fsm <= next_pstate_fsm;
         PREQ <= next_preq;
         PSTATE_BUSY <= next_pstate_busy;
         PSTATE_DONE <= next_pstate_done;
      end
   end

   // Target captured once so it stays stable for the whole handshake
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PSTATE <= lpc_pkg::PSTATE_RESET;
      end else if (start_req) begin
         PSTATE <= PSTATE_TARGET;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   sequence s_req_taken;
      pstate_fsm == lpc_pkg::PC_IDLE && PSTATE_REQ && !paccept_s;
   endsequence

   // Accept still seen after the request dropped, then the accept goes away
   sequence s_full_cycle;
      !PREQ && PSTATE_BUSY && paccept_s ##1 !paccept_s;
   endsequence

   // Pin checks assume the pins only move away from the sampling edge
   sequence s_clk_pin_low;
      $fell(CLK_QREQN) && CLK_QACCEPTN && !CLK_QDENY ##1 !CLK_QREQN [*2];
   endsequence

   sequence s_pwr_pin_low;
      $fell(PWR_QREQN) && PWR_QACCEPTN && !PWR_QDENY ##1 !PWR_QREQN [*2];
   endsequence

   a_sync_two_stage:
      assert property (rst_age == lpc_pkg::AGE_FULL |-> sync_out == $past(async_in, 2))
      else $error("Synchronizer is not two flip-flops deep");
   a_req_issue:
      assert property (s_req_taken |=> PREQ && PSTATE_BUSY)
      else $error("Power state request not raised");
   a_target_shown:
      assert property (s_req_taken |=> PSTATE == $past(PSTATE_TARGET))
      else $error("Target power state not presented");
   a_preq_hold:
      assert property (PREQ && !paccept_s |=> PREQ && $stable(PSTATE))
      else $error("Request or state changed before accept");
   a_preq_drop:
      assert property (PREQ && paccept_s |=> !PREQ)
      else $error("Request held after synchronized accept");
   a_wait_release:
      assert property (!PREQ && paccept_s |=> !PREQ)
      else $error("New request before accept released");
   a_done_pulse:
      assert property (s_full_cycle |=> PSTATE_DONE ##1 !PSTATE_DONE)
      else $error("Done pulse missing after full handshake");
   a_pwr_busy_deny:
      assert property (PREQ && pwr_q.qreqn ##1 !pwr_q.qreqn && PWR_QACCEPTN && !PWR_QDENY
                       |=> PWR_QDENY)
      else $error("Power quiescence accepted during state change");
   a_clk_answer_time:
      assert property (s_clk_pin_low |=> !CLK_QACCEPTN || CLK_QDENY)
      else $error("Clock channel answer not three edges after request");
   a_pwr_answer_time:
      assert property (s_pwr_pin_low |=> !PWR_QACCEPTN || PWR_QDENY)
      else $error("Power channel answer not three edges after request");
   a_preq_not_early:
      assert property (PREQ && !$past(PACCEPT, 2) |=> PREQ)
      else $error("Request dropped before accept passed the synchronizer");
   a_pstate_steady:
      assert property (PSTATE_BUSY |=> $stable(PSTATE))
      else $error("Power state changed during a handshake");
   a_req_busy_flag:
      assert property (PREQ |-> PSTATE_BUSY)
      else $error("Request raised without busy flag");
   a_pwr_active_busy:
      assert property (pstate_fsm != lpc_pkg::PC_IDLE |=> PWR_QACTIVE)
      else $error("Power active low during a power state change");
   a_clk_active_idle:
      assert property (!CTRL_BUSY && !CTRL_WAKE |=> !CLK_QACTIVE)
      else $error("Clock active high while idle");
   a_done_idle:
      assert property (PSTATE_DONE |-> !PSTATE_BUSY && !PREQ)
      else $error("Done while handshake still open");
endmodule

// ---- verif/lpc_far_model.sv ----
`timescale 1ns/1ps
module lpc_far_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic preq,
   input wire logic [3:0] dly,
   output logic paccept
);
   logic [3:0] cnt;
   // Takes every request and never asks on its own; dly sets prompt or slow
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         paccept <= 1'b0;
         cnt <= 4'h0;
      end else if (preq != paccept) begin
         if (cnt == dly) begin
            paccept <= preq;
            cnt <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic clk, rstn, clk_qreqn, pwr_qreqn, ctrl_busy, ctrl_wake, pst_req, paccept, preq;
   logic c_acc, c_deny, c_act, p_acc, p_deny, p_act, pst_busy, pst_done;
   logic [4:0] pst_tgt, pstate;
   logic [3:0] far_dly;
   logic [1:0] cpr = 2'h2, ppr = 2'h2, apr = 2'h0;
   logic rpr = 1'b0;
   logic [39:0] expq[$];
   int cyc = 0, num_errors = 0, samples_checked = 0;

   lpc_top lpc_top_inst (.CLK_SYS(clk), .RESETN(rstn), .CLK_QREQN(clk_qreqn),
      .CLK_QACCEPTN(c_acc), .CLK_QDENY(c_deny), .CLK_QACTIVE(c_act), .PWR_QREQN(pwr_qreqn),
      .PWR_QACCEPTN(p_acc), .PWR_QDENY(p_deny), .PWR_QACTIVE(p_act), .PREQ(preq),
      .PSTATE(pstate), .PACCEPT(paccept), .CTRL_BUSY(ctrl_busy), .CTRL_WAKE(ctrl_wake),
      .PSTATE_REQ(pst_req), .PSTATE_TARGET(pst_tgt), .PSTATE_BUSY(pst_busy),
      .PSTATE_DONE(pst_done));
   lpc_far_model lpc_far_model_inst (.clk(clk), .rstn(rstn), .preq(preq), .dly(far_dly),
      .paccept(paccept));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop;
      if (expq.size() != 0) num_errors++;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      // Whole run needs a few hundred cycles
      if (cyc == 2000) begin
         num_errors++;
         report_and_stop;
      end
   end

   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Kept sorted by due cycle so parallel drivers can share one queue
   task automatic push(input int c, input logic [7:0] code);
      int i;
      i = expq.size();
      while (i > 0 && expq[i-1][39:8] > c) i--;
      expq.insert(i, {32'(c), code});
   endtask

   task automatic ev(input logic c, input logic [7:0] code);
      if (c) begin
         if (expq.size() == 0) check({32'(cyc), code}, 40'h0);
         else check({32'(cyc), code}, expq.pop_front());
      end
   endtask

   always @(posedge clk) begin
      #1;
      if (rstn) begin
         ev({c_acc, c_deny} != cpr, {6'h08, c_acc, c_deny});
         ev({p_acc, p_deny} != ppr, {6'h10, p_acc, p_deny});
         ev({c_act, p_act} != apr, {6'h18, c_act, p_act});
         ev(preq && !rpr, {3'h4, pstate});
         ev(!preq && rpr, {3'h5, pstate});
         ev(pst_done, {7'h60, pst_busy});
      end
      cpr = {c_acc, c_deny};
      ppr = {p_acc, p_deny};
      apr = {c_act, p_act};
      rpr = preq;
   end

   task automatic q_req(input logic ch, input logic bsy, input logic dn, input int hold);
      logic [5:0] b;
      b = ch ? 6'h10 : 6'h08;
      @(negedge clk);
      if (bsy) push(cyc + 1, 8'h63);
      ctrl_busy = bsy;
      push(cyc + 3, {b, dn, dn});
      if (ch) pwr_qreqn = 1'b0;
      else clk_qreqn = 1'b0;
      repeat (hold) @(negedge clk);
      push(cyc + 3, {b, 2'h2});
      if (bsy) push(cyc + 1, 8'h60);
      ctrl_busy = 1'b0;
      if (ch) pwr_qreqn = 1'b1;
      else clk_qreqn = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   task automatic p_req(input logic [4:0] t, input logic [3:0] d);
      int n;
      @(negedge clk);
      n = cyc;
      far_dly = d;
      pst_req = 1'b1;
      pst_tgt = t;
      push(n + 1, {3'h4, t});
      push(n + 5 + d, {3'h5, t});
      push(n + 9 + 2 * d, 8'hC0);
      @(negedge clk);
      pst_req = 1'b0;
      repeat (2) @(negedge clk);
      // Request during a running handshake must vanish
      pst_req = 1'b1;
      pst_tgt = ~t;
      @(negedge clk);
      pst_req = 1'b0;
      while (cyc < n + 12 + 2 * d) @(negedge clk);
   endtask

   initial begin
      {clk_qreqn, pwr_qreqn, ctrl_busy, ctrl_wake, pst_req, rstn} = 6'h30;
      pst_tgt = 5'h00;
      far_dly = 4'h0;
      void'($urandom(32'hF337));
      repeat (3) @(negedge clk);
      check({26'h0, c_acc, c_deny, c_act, p_acc, p_deny, p_act, preq, pstate, pst_busy,
         pst_done}, {26'h0, 3'h4, 3'h4, 1'b0, lpc_pkg::PSTATE_RESET, 2'h0});
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      $display("test reset done");
      for (int k = 0; k < 8; k++) q_req(k[0], k[1], k[1], 3 + int'($urandom % 6));
      $display("test quiescence done");
      for (int k = 0; k < 12; k++) begin
         logic nw;
         // Ends high so power-state work later leaves both active outputs still
         nw = (k == 11) ? 1'b1 : 1'($urandom);
         @(negedge clk);
         if (nw != ctrl_wake) push(cyc + 1, {6'h18, nw, nw});
         ctrl_wake = nw;
      end
      $display("test activity done");
      for (int k = 0; k < 4; k++) p_req(5'($urandom), 4'(k * 3));
      fork
         p_req(5'h1F, 4'h6);
         begin
            repeat (2) @(negedge clk);
            q_req(1'b1, 1'b0, 1'b1, 5);
         end
      join
      $display("test power state done");
      report_and_stop;
   end
endmodule
